// ### hw/macrocell_params.svh
// register offsets, field positions, reset values and counts for the logic block
// assumes a 12-bit byte address from the AXI4-Lite slave
`ifndef MACROCELL_PARAMS_SVH
`define MACROCELL_PARAMS_SVH

`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_SIG 12'h008
`define OFS_PROT 12'h00c
`define OFS_PINS 12'h010
`define OFS_OUTS 12'h014
`define OFS_SW_BASE 12'h100
`define OFS_MODE_A_BASE 12'h200
`define OFS_MODE_B_BASE 12'h300
`define OFS_PT_BASE 12'h800

`define RST_RUN 1'b0
`define RST_PROT 1'b0
`define RST_SIG 16'h0000
`define RST_WORD 32'h0000_0000

`define SW_SEL_W 8
`define NUM_PT 5
`define NUM_SHARED_CLK 3

`define MA_OR 0
`define MA_CASC 5
`define MA_XOR 6
`define MA_DSEL 8
`define MA_FF 10
`define MA_CLK 13
`define MA_CE 15
`define MA_CLR 16
`define MA_SET 18
`define MA_OUTC 19
`define MA_FBC 20
`define MA_IO 21
`define MA_OE 23

`define MB_XOR_PT 0
`define MB_D_PT 3
`define MB_K_PT 6
`define MB_CLK_PT 9
`define MB_CE_PT 12
`define MB_CLR_PT 15
`define MB_SET_PT 18
`define MB_FOLD_PT 21
`define MB_OE_IDX 24
`define MB_CLR_PIN 28

`define EN_PIN_A 3
`define EN_PIN_B 2

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ### hw/macrocell_pkg.sv
// types shared by the logic block: bus carriers and configuration encodings
// assumes 32-bit AXI4-Lite data and 12-bit addresses
package macrocell_pkg;
    typedef struct packed {
        logic [11:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [11:0] araddr;
        logic arvalid;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_t;

    typedef enum logic [2:0] {FF_D = 3'd0, FF_T = 3'd1, FF_JK = 3'd2, FF_SR = 3'd3,
        FF_LATCH = 3'd4} ff_mode_t;
    typedef enum logic [1:0] {XOR_LOW = 2'd0, XOR_HIGH = 2'd1, XOR_PT = 2'd2} xor_sel_t;
    typedef enum logic [1:0] {D_XOR = 2'd0, D_PT = 2'd1, D_PIN = 2'd2} d_sel_t;
    typedef enum logic [1:0] {CLR_OFF = 2'd0, CLR_SHARED = 2'd1, CLR_PT = 2'd2,
        CLR_BOTH = 2'd3} clr_sel_t;
    typedef enum logic [1:0] {IO_INPUT = 2'd0, IO_OUTPUT = 2'd1, IO_BIDIR = 2'd2} io_mode_t;
    typedef enum logic [2:0] {OE_A = 3'd0, OE_A_N = 3'd1, OE_B = 3'd2, OE_B_N = 3'd3,
        OE_IOPIN = 3'd4, OE_MC = 3'd5} oe_sel_t;
endpackage

// ### hw/pld_macrocell_logic_block.sv
// one logic block: switch matrix, macrocells with product terms, sum logic,
// configurable storage element and output control, configured over AXI4-Lite
// assumes all pins synchronous to clk; shared clock lines are sampled and edge-detected
//
// Function
// R1: five product terms per macrocell, all inputs
// R2: switch matrix picks 40 global bus signals
// R3: feedback and pins drive global bus
// R4: each macrocell puts foldback on regional bus
// R5: selector routes product terms to functions
// R6: OR of five terms, cascade extends chain
// R7: XOR with product term or fixed level
// R8: data from XOR, product term or pin
// R9: D, T, JK, SR or latch storage
// R10: latch transparent while its clock high
// R11: clock from shared lines or term, rising
// R12: clock enable term blocks shared clock edges
// R13: clear from shared line, term, both, none
// R14: preset from product term or never
// R15: output registered or combinatorial
// R16: feedback source chosen independently of output
// R17: pin is input, output or bidirectional
// R18: enable from two pins, pins or macrocells
// R19: dedicated pins serve as clock, clear, enable
// R20: signature readable, protection hides configuration
// R21: foldback is inverted term, reaches block
// R22: configuration static while logic runs
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "macrocell_params.svh"

module pld_macrocell_logic_block #(
    parameter int NUM_MC = 16,
    parameter int SW_N = 40,
    parameter int EXT_W = 96
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire macrocell_pkg::axil_req_t bus_req,
    output macrocell_pkg::axil_rsp_t bus_rsp,
    input wire logic [3:0] ded_in,
    input wire logic [EXT_W-1:0] ext_gbus,
    input wire logic cascade_sum_in,
    input wire logic [NUM_MC-1:0] io_in,
    output logic [NUM_MC-1:0] io_out,
    output logic [NUM_MC-1:0] io_oe,
    output logic [NUM_MC-1:0] fb_out,
    output logic cascade_sum_out
);
    import macrocell_pkg::*;

    localparam int GB_W = 4 + NUM_MC + EXT_W + NUM_MC;
    localparam int PT_IN = SW_N + NUM_MC;

    // refuse sizes that the packed storage and read map cannot hold
    if (GB_W > (1 << `SW_SEL_W) || PT_IN > 64 || NUM_MC > 16 || NUM_MC < 1 || SW_N > 64)
    begin : g_bad_size
        $error("pld_macrocell_logic_block: parameters out of range");
    end

    typedef struct packed {
        axil_rsp_t rsp;
        logic aw_have;
        logic [11:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic run;
        logic prot;
        logic [15:0] sig;
        logic [SW_N-1:0][`SW_SEL_W-1:0] sw_sel;
        logic [NUM_MC-1:0][31:0] mode_a;
        logic [NUM_MC-1:0][31:0] mode_b;
        logic [NUM_MC-1:0][`NUM_PT-1:0][3:0][31:0] mask;
        logic [NUM_MC-1:0] ff;
        logic [NUM_MC-1:0] clk_prev;
        logic [NUM_MC-1:0] fold;
        logic [NUM_MC-1:0] fb;
        logic [NUM_MC-1:0] io_out;
        logic [NUM_MC-1:0] io_oe;
        logic casc;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [GB_W-1:0] gbus;
    logic [SW_N-1:0] sw;
    logic [PT_IN-1:0] pt_in;
    logic [NUM_MC:0] sum_chain;
    logic [NUM_MC-1:0] xo;
    logic [NUM_MC-1:0] d_in;
    logic [NUM_MC-1:0] k_in;
    logic [NUM_MC-1:0] clk_src;
    logic [NUM_MC-1:0] clk_en;
    logic [NUM_MC-1:0] clr;
    logic [NUM_MC-1:0] set;
    logic [NUM_MC-1:0] fold_d;
    logic [NUM_MC-1:0] oe_d;

    // global bus: dedicated pins, own pins, other blocks, own feedback
    assign gbus = {ded_in, io_in, ext_gbus, s_q.fb}; // [R3]
    assign pt_in = {s_q.fold, sw}; // [R4] [R21]
    assign sum_chain[0] = cascade_sum_in;

    genvar g;
    generate
        for (g = 0; g < SW_N; g++)
        begin : g_sw
            assign sw[g] = (int'(s_q.sw_sel[g]) < GB_W) ? gbus[s_q.sw_sel[g]] : 1'b0; // [R2]
        end

        for (g = 0; g < NUM_MC; g++)
        begin : g_mc
            logic [31:0] ma;
            logic [31:0] mb;
            logic [7:0] pt;
            logic [1:0] csel;
            logic [1:0] cpin;
            logic [3:0] oidx;
            logic xb;
            assign ma = s_q.mode_a[g];
            assign mb = s_q.mode_b[g];
            assign csel = ma[`MA_CLK +: 2];
            assign cpin = mb[`MB_CLR_PIN +: 2];
            assign oidx = mb[`MB_OE_IDX +: 4];
            for (genvar p = 0; p < `NUM_PT; p++)
            begin : g_pt
                logic [63:0] t_m;
                logic [63:0] c_m;
                assign t_m = {s_q.mask[g][p][1], s_q.mask[g][p][0]};
                assign c_m = {s_q.mask[g][p][3], s_q.mask[g][p][2]};
                // and of true and complemented literals
                assign pt[p] = &(pt_in | ~t_m[PT_IN-1:0]) & &(~pt_in | ~c_m[PT_IN-1:0]); // [R1]
            end
            assign pt[7:`NUM_PT] = '0;
            // [R5] each function takes the term its field picks
            assign sum_chain[g+1] = |(pt[`NUM_PT-1:0] & ma[`MA_OR +: `NUM_PT])
                | (ma[`MA_CASC] & sum_chain[g]); // [R6]
            always_comb
            begin
                case (xor_sel_t'(ma[`MA_XOR +: 2])) // [R7]
                    XOR_HIGH: xb = 1'b1;
                    XOR_PT: xb = pt[mb[`MB_XOR_PT +: 3]];
                    default: xb = 1'b0;
                endcase
            end
            assign xo[g] = sum_chain[g+1] ^ xb;
            always_comb
            begin
                case (d_sel_t'(ma[`MA_DSEL +: 2])) // [R8]
                    D_PT: d_in[g] = pt[mb[`MB_D_PT +: 3]];
                    D_PIN: d_in[g] = io_in[g];
                    default: d_in[g] = xo[g];
                endcase
            end
            assign k_in[g] = pt[mb[`MB_K_PT +: 3]];
            assign clk_src[g] = (int'(csel) < `NUM_SHARED_CLK) ? ded_in[csel]
                : pt[mb[`MB_CLK_PT +: 3]]; // [R11] [R19]
            assign clk_en[g] = (int'(csel) < `NUM_SHARED_CLK && ma[`MA_CE])
                ? pt[mb[`MB_CE_PT +: 3]] : 1'b1; // [R12]
            always_comb
            begin
                case (clr_sel_t'(ma[`MA_CLR +: 2])) // [R13] [R19]
                    CLR_SHARED: clr[g] = ded_in[cpin];
                    CLR_PT: clr[g] = pt[mb[`MB_CLR_PT +: 3]];
                    CLR_BOTH: clr[g] = ded_in[cpin] | pt[mb[`MB_CLR_PT +: 3]];
                    default: clr[g] = 1'b0;
                endcase
            end
            assign set[g] = ma[`MA_SET] & pt[mb[`MB_SET_PT +: 3]]; // [R14]
            assign fold_d[g] = ~pt[mb[`MB_FOLD_PT +: 3]]; // [R21]
            always_comb
            begin
                case (io_mode_t'(ma[`MA_IO +: 2])) // [R17]
                    IO_OUTPUT: oe_d[g] = 1'b1;
                    IO_BIDIR:
                    begin
                        case (oe_sel_t'(ma[`MA_OE +: 3])) // [R18] [R19]
                            OE_A: oe_d[g] = ded_in[`EN_PIN_A];
                            OE_A_N: oe_d[g] = ~ded_in[`EN_PIN_A];
                            OE_B: oe_d[g] = ded_in[`EN_PIN_B];
                            OE_B_N: oe_d[g] = ~ded_in[`EN_PIN_B];
                            OE_IOPIN: oe_d[g] = (int'(oidx) < NUM_MC) ? io_in[oidx] : 1'b0;
                            OE_MC: oe_d[g] = (int'(oidx) < NUM_MC) ? s_q.io_out[oidx] : 1'b0;
                            default: oe_d[g] = 1'b0;
                        endcase
                    end
                    default: oe_d[g] = 1'b0;
                endcase
            end
        end
    endgenerate

    function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] data,
        logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                r[8*b +: 8] = data[8*b +: 8];
            end
        end
        return r;
    endfunction

    // configuration areas: switch, mode and mask words
    function automatic logic in_cfg(logic [11:0] a);
        return (a >= `OFS_SW_BASE && int'(a) < int'(`OFS_SW_BASE) + 4 * SW_N)
            || (a >= `OFS_MODE_A_BASE && int'(a) < int'(`OFS_MODE_A_BASE) + 4 * NUM_MC)
            || (a >= `OFS_MODE_B_BASE && int'(a) < int'(`OFS_MODE_B_BASE) + 4 * NUM_MC)
            || (a >= `OFS_PT_BASE && int'(a) < int'(`OFS_PT_BASE) + 128 * NUM_MC
                && int'(a[6:4]) < `NUM_PT);
    endfunction

    always_comb
    begin
        int i;
        logic [11:0] a;
        logic [11:0] ra;
        logic [31:0] rd;
        logic [31:0] mw;
        logic hit;
        logic edge_ok;
        logic nq;
        s_d = s_q;
        i = 0;
        a = {s_q.aw_addr[11:2], 2'b00};
        ra = {bus_req.araddr[11:2], 2'b00};
        rd = `RST_WORD;
        mw = `RST_WORD;
        hit = 1'b0;
        edge_ok = 1'b0;
        nq = 1'b0;

        // write address and data are taken independently
        if (bus_req.awvalid && s_q.rsp.awready)
        begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = bus_req.awaddr;
        end
        if (bus_req.wvalid && s_q.rsp.wready)
        begin
            s_d.w_have = 1'b1;
            s_d.w_data = bus_req.wdata;
            s_d.w_strb = bus_req.wstrb;
        end
        if (s_q.rsp.bvalid && bus_req.bready)
        begin
            s_d.rsp.bvalid = 1'b0;
        end
        if (s_q.aw_have && s_q.w_have && !s_q.rsp.bvalid)
        begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.rsp.bvalid = 1'b1;
            s_d.rsp.bresp = `RESP_OKAY;
            if (in_cfg(a) && s_q.run)
            begin
                s_d.rsp.bresp = `RESP_SLVERR; // [R22]
            end
            else if (a == `OFS_CTRL)
            begin
                if (s_q.w_strb[0])
                begin
                    s_d.run = s_q.w_data[0];
                end
            end
            else if (a == `OFS_SIG)
            begin
                mw = merge({16'h0000, s_q.sig}, s_q.w_data, s_q.w_strb);
                s_d.sig = mw[15:0];
            end
            else if (a == `OFS_PROT)
            begin
                if (s_q.w_strb[0] && s_q.w_data[0])
                begin
                    s_d.prot = 1'b1;
                end
            end
            else if (in_cfg(a) && a >= `OFS_PT_BASE)
            begin
                i = int'(a - `OFS_PT_BASE);
                s_d.mask[i / 128][(i / 16) % 8][(i / 4) % 4] =
                    merge(s_q.mask[i / 128][(i / 16) % 8][(i / 4) % 4], s_q.w_data, s_q.w_strb);
            end
            else if (in_cfg(a) && a >= `OFS_MODE_B_BASE)
            begin
                i = int'(a - `OFS_MODE_B_BASE) / 4;
                s_d.mode_b[i] = merge(s_q.mode_b[i], s_q.w_data, s_q.w_strb);
            end
            else if (in_cfg(a) && a >= `OFS_MODE_A_BASE)
            begin
                i = int'(a - `OFS_MODE_A_BASE) / 4;
                s_d.mode_a[i] = merge(s_q.mode_a[i], s_q.w_data, s_q.w_strb);
            end
            else if (in_cfg(a))
            begin
                i = int'(a - `OFS_SW_BASE) / 4;
                mw = merge({24'h00_0000, s_q.sw_sel[i]}, s_q.w_data, s_q.w_strb);
                s_d.sw_sel[i] = mw[`SW_SEL_W-1:0];
            end
            else if (a != `OFS_STATUS && a != `OFS_PINS && a != `OFS_OUTS)
            begin
                s_d.rsp.bresp = `RESP_SLVERR;
            end
        end
        s_d.rsp.awready = !s_d.aw_have && !s_d.rsp.bvalid;
        s_d.rsp.wready = !s_d.w_have && !s_d.rsp.bvalid;

        // read path
        if (s_q.rsp.rvalid && bus_req.rready)
        begin
            s_d.rsp.rvalid = 1'b0;
        end
        if (bus_req.arvalid && s_q.rsp.arready)
        begin
            hit = 1'b1;
            if (ra == `OFS_CTRL)
            begin
                rd[0] = s_q.run;
            end
            else if (ra == `OFS_STATUS)
            begin
                rd[1:0] = {s_q.prot, s_q.run};
            end
            else if (ra == `OFS_SIG)
            begin
                rd[15:0] = s_q.sig; // [R20]
            end
            else if (ra == `OFS_PROT)
            begin
                rd[0] = s_q.prot;
            end
            else if (ra == `OFS_PINS)
            begin
                rd[NUM_MC-1:0] = io_in;
                rd[19:16] = ded_in;
            end
            else if (ra == `OFS_OUTS)
            begin
                rd[NUM_MC-1:0] = s_q.io_out;
                rd[16 +: NUM_MC] = s_q.fb;
            end
            else if (!in_cfg(ra))
            begin
                hit = 1'b0;
            end
            else if (s_q.prot)
            begin
                rd = `RST_WORD; // [R20]
            end
            else if (ra >= `OFS_PT_BASE)
            begin
                i = int'(ra - `OFS_PT_BASE);
                rd = s_q.mask[i / 128][(i / 16) % 8][(i / 4) % 4];
            end
            else if (ra >= `OFS_MODE_B_BASE)
            begin
                rd = s_q.mode_b[int'(ra - `OFS_MODE_B_BASE) / 4];
            end
            else if (ra >= `OFS_MODE_A_BASE)
            begin
                rd = s_q.mode_a[int'(ra - `OFS_MODE_A_BASE) / 4];
            end
            else
            begin
                rd[`SW_SEL_W-1:0] = s_q.sw_sel[int'(ra - `OFS_SW_BASE) / 4];
            end
            s_d.rsp.rvalid = 1'b1;
            s_d.rsp.rdata = rd;
            s_d.rsp.rresp = hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        s_d.rsp.arready = !s_d.rsp.rvalid;

        // macrocell storage and outputs
        for (int m = 0; m < NUM_MC; m++)
        begin
            nq = s_q.ff[m];
            edge_ok = clk_src[m] && !s_q.clk_prev[m] && clk_en[m]; // [R11] [R12]
            case (ff_mode_t'(s_q.mode_a[m][`MA_FF +: 3])) // [R9]
                FF_LATCH:
                begin
                    if (clk_src[m])
                    begin
                        nq = d_in[m]; // [R10]
                    end
                end
                FF_T:
                begin
                    if (edge_ok)
                    begin
                        nq = s_q.ff[m] ^ d_in[m];
                    end
                end
                FF_JK:
                begin
                    if (edge_ok)
                    begin
                        nq = (d_in[m] & ~s_q.ff[m]) | (~k_in[m] & s_q.ff[m]);
                    end
                end
                FF_SR:
                begin
                    if (edge_ok && (d_in[m] ^ k_in[m]))
                    begin
                        nq = d_in[m];
                    end
                end
                default:
                begin
                    if (edge_ok)
                    begin
                        nq = d_in[m];
                    end
                end
            endcase
            if (clr[m])
            begin
                nq = 1'b0; // [R13]
            end
            else if (set[m])
            begin
                nq = 1'b1; // [R14]
            end
            if (!s_q.run)
            begin
                nq = 1'b0;
            end
            s_d.ff[m] = nq;
            s_d.clk_prev[m] = clk_src[m];
            s_d.fold[m] = s_q.run & fold_d[m]; // [R4]
            s_d.io_out[m] = s_q.run & (s_q.mode_a[m][`MA_OUTC] ? xo[m] : nq); // [R15]
            s_d.fb[m] = s_q.run & (s_q.mode_a[m][`MA_FBC] ? xo[m] : nq); // [R16]
            s_d.io_oe[m] = s_q.run & oe_d[m]; // [R17]
        end
        s_d.casc = s_q.run & sum_chain[NUM_MC]; // [R6]
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s_q <= '0;
            s_q.run <= `RST_RUN;
            s_q.prot <= `RST_PROT;
            s_q.sig <= `RST_SIG;
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

    assign bus_rsp = s_q.rsp;
    assign io_out = s_q.io_out;
    assign io_oe = s_q.io_oe;
    assign fb_out = s_q.fb;
    assign cascade_sum_out = s_q.casc;
endmodule

// ### sim/pld_macrocell_logic_block_checker.sv
// checker for the logic block: bus handshakes, reset state, clock-enable freeze
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ns
`include "macrocell_params.svh"

module pld_macrocell_logic_block_checker #(
    parameter int NUM_MC = 16,
    parameter int SW_N = 40,
    parameter int EXT_W = 96
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire macrocell_pkg::axil_req_t bus_req,
    input wire macrocell_pkg::axil_rsp_t bus_rsp,
    input wire logic [3:0] ded_in,
    input wire logic [EXT_W-1:0] ext_gbus,
    input wire logic cascade_sum_in,
    input wire logic [NUM_MC-1:0] io_in,
    input wire logic [NUM_MC-1:0] io_out,
    input wire logic [NUM_MC-1:0] io_oe,
    input wire logic [NUM_MC-1:0] fb_out,
    input wire logic cascade_sum_out
);
    import macrocell_pkg::*;
    logic ar_hs;
    assign ar_hs = bus_req.arvalid && bus_rsp.arready && ce;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_reset_quiet;
        $fell(srst) |-> io_out == '0 && io_oe == '0 && fb_out == '0 && !bus_rsp.bvalid;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs not idle after reset");
    property p_ready_after_reset;
        $fell(srst) && ce |=> bus_rsp.awready && bus_rsp.wready && bus_rsp.arready;
    endproperty
    a_ready_after_reset: assert property (p_ready_after_reset)
        else $error("bus not ready after reset");
    property p_read_answer;
        ar_hs |=> bus_rsp.rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read answer late");
    property p_write_answer;
        bus_req.awvalid && bus_rsp.awready && bus_req.wvalid && bus_rsp.wready && ce
            ##1 ce |=> bus_rsp.bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("write answer late");
    property p_aw_blocked;
        bus_req.awvalid && bus_rsp.awready && ce |=> !bus_rsp.awready [*2];
    endproperty
    a_aw_blocked: assert property (p_aw_blocked)
        else $error("address taken twice");
    property p_r_done;
        bus_rsp.rvalid && bus_req.rready && ce |=> !bus_rsp.rvalid;
    endproperty
    a_r_done: assert property (p_r_done)
        else $error("read data not retired");
    property p_no_ar_while_r;
        bus_rsp.rvalid |-> !bus_rsp.arready;
    endproperty
    a_no_ar_while_r: assert property (p_no_ar_while_r)
        else $error("read address ready while data pending");
    property p_unmapped_read;
        ar_hs && bus_req.araddr inside {[12'h018:12'h0fc]} |=> bus_rsp.rresp == `RESP_SLVERR;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read not refused");
    property p_sig_okay;
        ar_hs && bus_req.araddr == `OFS_SIG |=> bus_rsp.rresp == `RESP_OKAY;
    endproperty
    a_sig_okay: assert property (p_sig_okay)
        else $error("signature read refused");
    property p_ce_freeze;
        !ce |=> $stable(io_out) && $stable(io_oe) && $stable(fb_out);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze)
        else $error("outputs moved while frozen");

    c_write: cover property (bus_rsp.bvalid && bus_req.bready);
    c_read: cover property (bus_rsp.rvalid && bus_req.rready);
    c_oe_rise: cover property ($rose(io_oe[0]));
endmodule

bind pld_macrocell_logic_block pld_macrocell_logic_block_checker #(
    .NUM_MC(NUM_MC), .SW_N(SW_N), .EXT_W(EXT_W)
) u_pld_macrocell_logic_block_checker (
    .clk(clk), .srst(srst), .ce(ce), .bus_req(bus_req), .bus_rsp(bus_rsp),
    .ded_in(ded_in), .ext_gbus(ext_gbus), .cascade_sum_in(cascade_sum_in),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .fb_out(fb_out),
    .cascade_sum_out(cascade_sum_out)
);

// ### sim/testbench.sv
// self-checking bench for the logic block over its AXI4-Lite port
// assumes the block, its package and parameter header compile ahead of it
`timescale 1ns/1ns
`include "macrocell_params.svh"

`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin errors++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end

module testbench;
    import macrocell_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    axil_req_t req = '0;
    axil_rsp_t rsp;
    logic [3:0] ded = 4'h0;
    logic [15:0] pins = 16'h0000;
    logic [15:0] io_in;
    logic [15:0] io_out;
    logic [15:0] io_oe;
    logic [15:0] fb;
    logic casc_in = 1'b0;
    logic casc_out;
    logic [1:0] resp;
    logic [31:0] rdat;
    logic p;
    int errors = 0;
    int checks_done = 0;

    always #50 clk = ~clk;
    // pin wire: block drives where enabled, bench elsewhere
    assign io_in = (io_oe & io_out) | (~io_oe & pins);

    pld_macrocell_logic_block u_pld_macrocell_logic_block (
        .clk(clk), .srst(srst), .ce(ce), .bus_req(req), .bus_rsp(rsp), .ded_in(ded),
        .ext_gbus(96'h0), .cascade_sum_in(casc_in), .io_in(io_in), .io_out(io_out),
        .io_oe(io_oe), .fb_out(fb), .cascade_sum_out(casc_out)
    );

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        req.awaddr <= a;
        req.awvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (rsp.awready)
                req.awvalid <= 1'b0;
            if (rsp.wready)
                req.wvalid <= 1'b0;
            if (rsp.bvalid)
            begin
                resp = rsp.bresp;
                req.bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (rsp.arready)
                req.arvalid <= 1'b0;
            if (rsp.rvalid)
            begin
                rdat = rsp.rdata;
                resp = rsp.rresp;
                req.rready <= 1'b0;
                break;
            end
        end
    endtask

    // mode of macrocell 0 can only change while stopped
    task automatic cfg(input logic [31:0] ma);
        wr(`OFS_CTRL, 32'h0);
        wr(`OFS_MODE_A_BASE, ma);
        wr(`OFS_CTRL, 32'h1);
    endtask

    task automatic settle;
        repeat (4) @(posedge clk);
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        report_and_stop;
    end

    initial
    begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rd(`OFS_CTRL);
        `CHK("ctrl", 32'h0, rdat);
        rd(`OFS_SIG);
        `CHK("sig reset", 32'h0, rdat);
        rd(12'h018);
        `CHK("unmapped resp", `RESP_SLVERR, resp);
        wr(`OFS_SIG, 32'h0000_beef);
        // switch 0 and 1 pick pins 8 and 9; terms 0 and 1 take one each
        wr(`OFS_SW_BASE, 32'h78);
        wr(`OFS_SW_BASE + 12'h4, 32'h79);
        wr(`OFS_PT_BASE, 32'h1);
        wr(`OFS_PT_BASE + 12'h10, 32'h2);
        // macrocell 15 sums its empty term, so the chain end is high while running
        wr(`OFS_MODE_A_BASE + 12'h3c, 32'h1);
        for (int pol = 0; pol < 2; pol++)
        begin
            p = pol[0];
            cfg(32'h0048_0003 | (pol << 6));
            ded <= 4'h8;
            pins <= 16'h0000;
            settle;
            `CHK("out idle", p, io_out[0]);
            `CHK("oe pin A", 1'b1, io_oe[0]);
            pins <= 16'h0100;
            settle;
            `CHK("out a", ~p, io_out[0]);
            `CHK("fb before edge", 1'b0, fb[0]);
            ded <= 4'h9;
            settle;
            `CHK("fb after edge", ~p, fb[0]);
            pins <= 16'h0000;
            ded <= 4'h8;
            settle;
            `CHK("out none", p, io_out[0]);
            `CHK("fb held", ~p, fb[0]);
            pins <= 16'h0200;
            ded <= 4'h0;
            settle;
            `CHK("out b", ~p, io_out[0]);
            `CHK("oe off", 1'b0, io_oe[0]);
        end
        wr(`OFS_MODE_A_BASE, 32'h0);
        `CHK("locked write", `RESP_SLVERR, resp);
        rd(`OFS_MODE_A_BASE);
        `CHK("config kept", 32'h0048_0043, rdat);
        cfg(32'h0040_1003);
        ded <= 4'h9;
        pins <= 16'h0100;
        settle;
        `CHK("latch open", 1'b1, io_out[0]);
        ce <= 1'b0;
        pins <= 16'h0000;
        settle;
        `CHK("frozen", 1'b1, io_out[0]);
        ce <= 1'b1;
        ded <= 4'h8;
        settle;
        `CHK("latch closed", 1'b1, io_out[0]);
        ded <= 4'h9;
        settle;
        `CHK("latch follows", 1'b0, io_out[0]);
        cfg(32'h0048_0023);
        casc_in <= 1'b1;
        settle;
        `CHK("cascade in", 1'b1, io_out[0]);
        `CHK("cascade out", 1'b1, casc_out);
        casc_in <= 1'b0;
        settle;
        `CHK("cascade off", 1'b0, io_out[0]);
        wr(`OFS_PROT, 32'h1);
        rd(`OFS_STATUS);
        `CHK("status", 32'h3, rdat);
        rd(`OFS_MODE_A_BASE);
        `CHK("hidden config", 32'h0, rdat);
        rd(`OFS_SIG);
        `CHK("signature", 32'h0000_beef, rdat);
        report_and_stop;
    end
endmodule
